// file: irq_pkg.sv
// constants, register map and state encodings shared by the edge-detect
// interrupt block and its per-pin detector
// assumes an 8-bit register port and one 40 MHz clock
package irq_pkg;

   localparam int NUM_PINS = 8;
   localparam int VEC_W    = 3;
   localparam int LVL_W    = 2;

   // register map, index on reg_addr
   localparam logic [3:0] ADDR_RISE    = 4'h0;
   localparam logic [3:0] ADDR_FALL    = 4'h1;
   localparam logic [3:0] ADDR_STATUS  = 4'h2;
   localparam logic [3:0] ADDR_MASK    = 4'h3;
   localparam logic [3:0] ADDR_PRIO_LO = 4'h4;
   localparam logic [3:0] ADDR_PRIO_HI = 4'h5;
   localparam logic [3:0] ADDR_CTRL    = 4'h6;
   localparam logic [3:0] ADDR_SVC     = 4'h7;
   localparam logic [3:0] ADDR_BITOP   = 4'h8;

   // reset values
   localparam logic [7:0]  RISE_RST   = 8'h00;
   localparam logic [7:0]  FALL_RST   = 8'h00;
   localparam logic [7:0]  STATUS_RST = 8'h00;
   localparam logic [7:0]  MASK_RST   = 8'h00;
   localparam logic [15:0] PRIO_RST   = 16'hFFFF;
   localparam logic        ACK_EN_RST = 1'b0;

   // field positions
   localparam int CTRL_ACK_EN  = 0;
   localparam int BITOP_VAL    = 7;
   localparam int BITOP_FALL   = 6;
   localparam int BITOP_IDX_LO = 0;

   // priority levels, lower code is more urgent
   localparam logic [1:0] LEVEL_HIGHEST = 2'h0;
   localparam logic [1:0] LEVEL_LOWEST  = 2'h3;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_SERVICE = 2'b01,
      ST_NESTED  = 2'b10,
      ST_HOLD    = 2'b11
   } svc_state_e;

endpackage : irq_pkg

// file: edge_sel_if.sv
// selection bits and detected edge between the controller and one detector
// assumes both ends run on mclk
interface edge_sel_if;
   logic rise_sel_bit;
   logic fall_sel_bit;
   logic edge_pulse;

   modport ctrl (output rise_sel_bit, output fall_sel_bit, input edge_pulse);
   modport det  (input rise_sel_bit, input fall_sel_bit, output edge_pulse);
endinterface : edge_sel_if

// file: pin_edge_detect.sv
// synchroniser and edge detector for one external interrupt pin
// assumes the pin is asynchronous to mclk; edge_pulse is one cycle long
module pin_edge_detect (
   input  wire logic mclk,
   input  wire logic sys_rst,
   input  wire logic ext_irq_pin,
   edge_sel_if.det   sel
);
   import irq_pkg::*;

   typedef struct packed {
      logic       sync1;
      logic       sync2;
      logic       prev;
      logic [2:0] armed;
      logic       pulse;
   } det_s;

   det_s st;
   det_s next_st;

   // first stage feeds only the second; armed waits until prev holds a real
   // pin level, so a pin that is high through reset gives no false edge
   always_comb begin
      next_st       = st;
      next_st.sync1 = ext_irq_pin;
      next_st.sync2 = st.sync1;
      next_st.prev  = st.sync2;
      next_st.armed = {st.armed[1:0], 1'b1};
      next_st.pulse = st.armed[2] &
                      ((sel.rise_sel_bit & st.sync2 & ~st.prev) |   // R1 R9
                       (sel.fall_sel_bit & ~st.sync2 & st.prev));   // R1 R9
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sel.edge_pulse = st.pulse;

   a_rise_pulse: assert property (@(posedge mclk) disable iff (sys_rst) // R1
      (sel.rise_sel_bit && st.armed[2] && st.sync2 && !st.prev) |=> sel.edge_pulse)
      else $error("selected rising edge gave no pulse");
   a_fall_pulse: assert property (@(posedge mclk) disable iff (sys_rst) // R1
      (sel.fall_sel_bit && st.armed[2] && !st.sync2 && st.prev) |=> sel.edge_pulse)
      else $error("selected falling edge gave no pulse");
   a_none_sel: assert property (@(posedge mclk) disable iff (sys_rst) // R1
      (!sel.rise_sel_bit && !sel.fall_sel_bit) |=> !sel.edge_pulse)
      else $error("pulse with detection disabled");
   c_edge_seen: cover property (@(posedge mclk) disable iff (sys_rst) sel.edge_pulse);

endmodule : pin_edge_detect

// file: ext_irq_edge_and_priority.sv
// edge-selectable external interrupt controller with priority acceptance
// assumes a single-cycle register port on mclk and core handshakes on mclk
//
// Local design decisions: the register addresses and strobed register access.

// Summary of operation
// R1: per pin, rise/fall bit pair selects none, falling, rising or both edges
// R2: reset clears both edge-enable registers, disabling all detection
// R3: edge-enable registers accept whole-byte writes or single-bit writes
// R4: bit n of both edge-enable registers controls only pin n
// R5: software clears both enable bits before giving the pin back to port use
// R6: two-bit priority code 00 is level 0, highest, through 11, lowest
// R7: acknowledge-enable flag 0 blocks acceptance, 1 permits it
// R8: un-nested request waits until one main-program instruction has run
// R9: pins are synchronised and compared with last level for one-cycle pulses
module ext_irq_edge_and_priority (
   input  wire logic                   mclk,
   input  wire logic                   sys_rst,
   input  wire logic [3:0]             reg_addr,
   input  wire logic [7:0]             reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [7:0]             reg_rdata,
   input  wire logic [irq_pkg::NUM_PINS-1:0] ext_irq_pin,
   input  wire logic                   isr_return,
   input  wire logic                   insn_done,
   output logic                        ack_valid,
   output logic      [irq_pkg::VEC_W-1:0] ack_vector,
   output logic      [irq_pkg::LVL_W-1:0] ack_level,
   output logic                        in_service,
   output logic                        irq
);
   import irq_pkg::*;

   typedef struct packed {
      logic [7:0]            rise;
      logic [7:0]            fall;
      logic [7:0]            status;
      logic [7:0]            mask;
      logic [7:0][1:0]       prio;
      logic                  ack_en;
      svc_state_e            state;
      logic [LVL_W-1:0]      cur_level;
      logic [LVL_W-1:0]      saved_level;
      logic [VEC_W-1:0]      cur_vec;
      logic                  ack_valid;
      logic [VEC_W-1:0]      ack_vector;
      logic [LVL_W-1:0]      ack_level;
      logic [7:0]            rdata;
   } ctrl_s;

   ctrl_s st;
   ctrl_s next_st;

   logic [NUM_PINS-1:0] edges;
   logic [NUM_PINS-1:0] pend;
   logic                cand_ok;
   logic [VEC_W-1:0]    cand_vec;
   logic [LVL_W-1:0]    cand_lvl;
   logic [7:0]          clr;
   logic [7:0]          take;
   logic [VEC_W-1:0]    bit_idx;

   edge_sel_if esel [NUM_PINS] ();

   // one detector per pin; the selection pair of pin n goes to pin n only
   for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
      assign esel[g].rise_sel_bit = st.rise[g];   // R4
      assign esel[g].fall_sel_bit = st.fall[g];   // R4
      assign edges[g]             = esel[g].edge_pulse;

      pin_edge_detect u_det (
         .mclk        (mclk),
         .sys_rst     (sys_rst),
         .ext_irq_pin (ext_irq_pin[g]),
         .sel         (esel[g])
      );
   end

   assign pend    = st.status & st.mask;
   assign bit_idx = reg_wdata[BITOP_IDX_LO +: VEC_W];

   // most urgent pending request; ties go to the lower pin number
   always_comb begin
      cand_ok  = 1'b0;
      cand_vec = '0;
      cand_lvl = LEVEL_LOWEST;
      for (int i = NUM_PINS - 1; i >= 0; i--) begin
         if (pend[i] && (!cand_ok || st.prio[i] <= cand_lvl)) begin   // R6
            cand_ok  = 1'b1;
            cand_vec = VEC_W'(i);
            cand_lvl = st.prio[i];
         end
      end
   end

   // register writes, acceptance sequencer and read mux
   always_comb begin
      next_st           = st;
      next_st.ack_valid = 1'b0;
      next_st.rdata     = 8'h00;
      clr               = 8'h00;
      take              = 8'h00;

      if (reg_wr) begin
         case (reg_addr)
            ADDR_RISE:    next_st.rise = reg_wdata;        // R3
            ADDR_FALL:    next_st.fall = reg_wdata;        // R3
            ADDR_STATUS:  clr = reg_wdata;
            ADDR_MASK:    next_st.mask = reg_wdata;
            ADDR_PRIO_LO: next_st.prio[3:0] = reg_wdata;
            ADDR_PRIO_HI: next_st.prio[7:4] = reg_wdata;
            ADDR_CTRL:    next_st.ack_en = reg_wdata[CTRL_ACK_EN];
            ADDR_BITOP: begin
               // single-bit update, the other seven bits keep their value
               if (reg_wdata[BITOP_FALL]) begin
                  next_st.fall[bit_idx] = reg_wdata[BITOP_VAL];   // R3
               end else begin
                  next_st.rise[bit_idx] = reg_wdata[BITOP_VAL];   // R3
               end
            end
            default: ;
         endcase
      end

      // acceptance clears the flag, so the routine runs un-nested by default
      case (st.state)
         ST_IDLE: begin
            if (st.ack_en && cand_ok) begin                 // R7
               take[cand_vec]     = 1'b1;
               next_st.ack_en     = 1'b0;
               next_st.ack_valid  = 1'b1;
               next_st.ack_vector = cand_vec;
               next_st.ack_level  = cand_lvl;
               next_st.cur_vec    = cand_vec;
               next_st.cur_level  = cand_lvl;
               next_st.state      = ST_SERVICE;
            end
         end
         ST_SERVICE: begin
            if (isr_return) begin
               next_st.ack_en = 1'b1;
               next_st.state  = ST_HOLD;                    // R8
            end else if (st.ack_en && cand_ok && cand_lvl < st.cur_level) begin
               // routine re-enabled: only a more urgent level may nest
               take[cand_vec]      = 1'b1;
               next_st.ack_en      = 1'b0;
               next_st.ack_valid   = 1'b1;
               next_st.ack_vector  = cand_vec;
               next_st.ack_level   = cand_lvl;
               next_st.saved_level = st.cur_level;
               next_st.cur_vec     = cand_vec;
               next_st.cur_level   = cand_lvl;
               next_st.state       = ST_NESTED;
            end
         end
         ST_NESTED: begin
            // one nesting level only; deeper requests wait
            if (isr_return) begin
               next_st.ack_en    = 1'b1;
               next_st.cur_level = st.saved_level;
               next_st.state     = ST_SERVICE;
            end
         end
         ST_HOLD: begin
            if (insn_done) begin                            // R8
               next_st.state = ST_IDLE;
            end
         end
         default: next_st.state = ST_IDLE;
      endcase

      // a new edge wins over a clear in the same cycle
      next_st.status = (st.status & ~clr & ~take) | edges;   // R9

      if (reg_rd) begin
         case (reg_addr)
            ADDR_RISE:    next_st.rdata = st.rise;
            ADDR_FALL:    next_st.rdata = st.fall;
            ADDR_STATUS:  next_st.rdata = st.status;
            ADDR_MASK:    next_st.rdata = st.mask;
            ADDR_PRIO_LO: next_st.rdata = st.prio[3:0];
            ADDR_PRIO_HI: next_st.rdata = st.prio[7:4];
            ADDR_CTRL:    next_st.rdata = {7'h00, st.ack_en};
            ADDR_SVC:     next_st.rdata = {1'b0, st.state, st.cur_level, st.cur_vec};
            default:      next_st.rdata = 8'h00;
         endcase
      end
   end

   // state register; reset disables every edge and blocks acceptance
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st             <= '0;
         st.rise        <= RISE_RST;     // R2
         st.fall        <= FALL_RST;     // R2
         st.status      <= STATUS_RST;
         st.mask        <= MASK_RST;
         st.prio        <= PRIO_RST;
         st.ack_en      <= ACK_EN_RST;
         st.state       <= ST_IDLE;
         st.cur_level   <= LEVEL_LOWEST;
         st.saved_level <= LEVEL_LOWEST;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state copy
   assign reg_rdata  = st.rdata;
   assign ack_valid  = st.ack_valid;
   assign ack_vector = st.ack_vector;
   assign ack_level  = st.ack_level;
   assign in_service = (st.state == ST_SERVICE) || (st.state == ST_NESTED);
   assign irq        = |pend;   // level, high while an unmasked flag stands

   // helper copies for the checks below
   logic [1:0] prio_prev;
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         prio_prev <= LEVEL_LOWEST;
      end else begin
         prio_prev <= st.prio[cand_vec];
      end
   end

   // independent view of the winner: no pending request may beat it
   logic [NUM_PINS-1:0] beats_cand;
   always_comb begin
      beats_cand = '0;
      for (int i = 0; i < NUM_PINS; i++) begin
         beats_cand[i] = pend[i] &&
                         ((st.prio[i] < cand_lvl) ||
                          (st.prio[i] == cand_lvl && VEC_W'(i) < cand_vec));
      end
   end

   a_most_urgent: assert property (@(posedge mclk) disable iff (sys_rst) // R6
      cand_ok |-> (beats_cand == '0 && pend[cand_vec]))
      else $error("candidate is not the most urgent pending request");

   a_nest_lower: assert property (@(posedge mclk) disable iff (sys_rst) // R6
      (ack_valid && st.state == ST_NESTED) |-> (ack_level < st.saved_level))
      else $error("nested request not more urgent than the outer one");

   a_disabled_blocks: assert property (@(posedge mclk) disable iff (sys_rst) // R7
      !st.ack_en |=> !ack_valid)
      else $error("acceptance while the acknowledge flag was clear");

   a_nested_none: assert property (@(posedge mclk) disable iff (sys_rst) // R8
      (st.state == ST_NESTED) |=> !ack_valid)
      else $error("second nesting level accepted");

   a_return_enables: assert property (@(posedge mclk) disable iff (sys_rst) // R8
      (st.state == ST_SERVICE && isr_return) |=> (st.state == ST_HOLD && st.ack_en))
      else $error("return did not hold and re-enable acknowledge");

   a_fall_write: assert property (@(posedge mclk) disable iff (sys_rst) // R3
      (reg_wr && reg_addr == ADDR_FALL) |=> st.fall == $past(reg_wdata))
      else $error("byte write to falling enables lost");

   a_fall_bit: assert property (@(posedge mclk) disable iff (sys_rst) // R3
      (reg_wr && reg_addr == ADDR_BITOP && reg_wdata[BITOP_FALL])
      |=> st.rise == $past(st.rise) &&
          st.fall[$past(bit_idx)] == $past(reg_wdata[BITOP_VAL]) &&
          ((st.fall ^ $past(st.fall)) & ~(8'h01 << $past(bit_idx))) == 8'h00)
      else $error("single-bit write disturbed falling enables");

   a_reset_clears: assert property (@(posedge mclk) // R2
      $past(sys_rst) |-> (st.rise == RISE_RST && st.fall == FALL_RST))
      else $error("edge enables not cleared by reset");

   a_byte_write: assert property (@(posedge mclk) disable iff (sys_rst) // R3
      (reg_wr && reg_addr == ADDR_RISE) |=> st.rise == $past(reg_wdata))
      else $error("byte write to rising enables lost");

   a_bit_write: assert property (@(posedge mclk) disable iff (sys_rst) // R3
      (reg_wr && reg_addr == ADDR_BITOP && !reg_wdata[BITOP_FALL])
      |=> st.fall == $past(st.fall) &&
          st.rise[$past(bit_idx)] == $past(reg_wdata[BITOP_VAL]) &&
          ((st.rise ^ $past(st.rise)) & ~(8'h01 << $past(bit_idx))) == 8'h00)
      else $error("single-bit write disturbed other bits");

   a_ack_needs_en: assert property (@(posedge mclk) disable iff (sys_rst) // R7
      ack_valid |-> ($past(st.ack_en) && !st.ack_en))
      else $error("request accepted while acknowledge disabled");

   a_ack_level: assert property (@(posedge mclk) disable iff (sys_rst) // R6
      ack_valid |-> ack_level == prio_prev)
      else $error("accepted level does not match priority field");

   a_hold_wait: assert property (@(posedge mclk) disable iff (sys_rst) // R8
      (st.state == ST_SERVICE && isr_return) |=> !ack_valid ##1 !ack_valid)
      else $error("request accepted straight after return");

   a_hold_insn: assert property (@(posedge mclk) disable iff (sys_rst) // R8
      (st.state == ST_HOLD && !insn_done) |=> (st.state == ST_HOLD && !ack_valid))
      else $error("hold left without a main-program instruction");

   a_edge_sets: assert property (@(posedge mclk) disable iff (sys_rst) // R9
      (edges != 8'h00) |=> (st.status & $past(edges)) == $past(edges))
      else $error("detected edge did not set its flag");

   c_accept:  cover property (@(posedge mclk) disable iff (sys_rst) ack_valid);
   c_nest:    cover property (@(posedge mclk) disable iff (sys_rst)
      st.state == ST_NESTED);
   c_release: cover property (@(posedge mclk) disable iff (sys_rst)
      st.state == ST_HOLD ##1 st.state == ST_IDLE);

endmodule : ext_irq_edge_and_priority

// file: ext_pin_model.sv
// far-side model of the eight external interrupt request pins
// assumes the bench names the wanted pin levels; the pins move on the
// falling clock edge so that they stay unrelated to the sampling edge
module ext_pin_model (
   input  wire logic       mclk,
   input  wire logic [7:0] want,
   output logic      [7:0] ext_irq_pin
);
   timeunit 1ns;
   timeprecision 1ps;

   // pins are plain levels driven by outside logic; no pull or release state
   // move away from the rising edge so the synchroniser sees a true async input
   always @(negedge mclk) begin
      ext_irq_pin <= want;
   end
endmodule // ext_pin_model

// file: ext_irq_edge_and_priority_tb_top.sv
// self-checking bench for the edge-detect interrupt controller
// assumes the register port, pins and core pulses of the design top
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module ext_irq_edge_and_priority_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import irq_pkg::*;

   logic        mclk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [3:0]  reg_addr = 4'h0;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_rdata;
   logic [7:0]  want = 8'h00;
   logic [7:0]  ext_irq_pin;
   logic        isr_return = 1'b0;
   logic        insn_done = 1'b0;
   logic        ack_valid;
   logic [2:0]  ack_vector;
   logic [1:0]  ack_level;
   logic        in_service;
   logic        irq;
   int          bad_count = 0;
   int          comparisons = 0;

   // 40 MHz clock
   always #12.5 mclk = ~mclk;

   ext_pin_model pins (.mclk(mclk), .want(want), .ext_irq_pin(ext_irq_pin));

   ext_irq_edge_and_priority DUT (
      .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ext_irq_pin(ext_irq_pin), .isr_return(isr_return), .insn_done(insn_done),
      .ack_valid(ack_valid), .ack_vector(ack_vector), .ack_level(ack_level),
      .in_service(in_service), .irq(irq)
   );

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // one-cycle write strobe; the write lands at the edge that drops it
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe, so look just then
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask

   task automatic pulse_ret(input logic which);
      @(posedge mclk);
      if (which) isr_return <= 1'b1; else insn_done <= 1'b1;
      @(posedge mclk);
      isr_return <= 1'b0;
      insn_done <= 1'b0;
   endtask

   // the acceptance pulse is one cycle wide, so poll every edge under a bound
   task automatic wait_ack(input logic [2:0] v, input logic [1:0] l);
      logic seen;
      seen = 1'b0;
      for (int i = 0; i < 8 && !seen; i++) begin
         @(posedge mclk);
         #1;
         if (ack_valid === 1'b1) seen = 1'b1;
      end
      `CHK(seen, 1'b1)
      `CHK(ack_vector, v)
      `CHK(ack_level, l)
   endtask

   task automatic no_ack(input int n);
      repeat (n) begin
         @(posedge mclk);
         #1;
         `CHK(ack_valid, 1'b0)
      end
   endtask

   task automatic end_sim;
      if (bad_count == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // watchdog: the whole sequence needs well under 2000 cycles
   initial begin
      #(25ns * 5000);
      bad_count++;
      end_sim();
   end

   // main sequence
   initial begin
      cyc(3);
      sys_rst <= 1'b0;
      cyc(3);
      rd_chk(ADDR_RISE, 8'h00);
      rd_chk(ADDR_FALL, 8'h00);
      rd_chk(ADDR_STATUS, 8'h00);
      rd_chk(4'hF, 8'h00);
      // byte write, then a single-bit set and clear on the rising register and a set on the falling one
      wr(ADDR_RISE, 8'hA5);
      wr(ADDR_BITOP, 8'h81);
      rd_chk(ADDR_RISE, 8'hA7);
      wr(ADDR_BITOP, 8'h07);
      rd_chk(ADDR_RISE, 8'h27);
      wr(ADDR_BITOP, 8'hC0);
      rd_chk(ADDR_FALL, 8'h01);
      rd_chk(ADDR_RISE, 8'h27);
      // all four edge modes on pin 3 while every pin toggles
      for (int m = 0; m < 4; m++) begin
         wr(ADDR_RISE, m[1] ? 8'h08 : 8'h00);
         wr(ADDR_FALL, m[0] ? 8'h08 : 8'h00);
         wr(ADDR_STATUS, 8'hFF);
         want <= 8'hFF;
         cyc(6);
         rd_chk(ADDR_STATUS, m[1] ? 8'h08 : 8'h00);
         wr(ADDR_STATUS, 8'hFF);
         want <= 8'h00;
         cyc(6);
         rd_chk(ADDR_STATUS, m[0] ? 8'h08 : 8'h00);
         wr(ADDR_STATUS, 8'hFF);
      end
      // a steady pin must not raise a second request
      cyc(6);
      rd_chk(ADDR_STATUS, 8'h00);
      // two requests: pin 2 at level 3, pin 5 at level 0
      wr(ADDR_RISE, 8'h24);
      wr(ADDR_FALL, 8'h00);
      wr(ADDR_PRIO_LO, 8'hFF);
      wr(ADDR_PRIO_HI, 8'hF3);
      want <= 8'h24;
      cyc(6);
      rd_chk(ADDR_STATUS, 8'h24);
      #1;
      `CHK(irq, 1'b0)
      wr(ADDR_MASK, 8'h24);
      #1;
      `CHK(irq, 1'b1)
      no_ack(8);
      wr(ADDR_CTRL, 8'h01);
      wait_ack(3'd5, 2'd0);
      `CHK(in_service, 1'b1)
      rd_chk(ADDR_STATUS, 8'h04);
      // no re-enable inside the routine: pin 2 waits, no nesting
      no_ack(10);
      `CHK(in_service, 1'b1)
      pulse_ret(1'b1);
      no_ack(6);
      `CHK(in_service, 1'b0)
      pulse_ret(1'b0);
      wait_ack(3'd2, 2'd3);
      rd_chk(ADDR_STATUS, 8'h00);
      // routine re-enables: a more urgent falling edge on pin 5 nests
      wr(ADDR_CTRL, 8'h01);
      wr(ADDR_FALL, 8'h20);
      want <= 8'h04;
      wait_ack(3'd5, 2'd0);
      rd_chk(ADDR_SVC, 8'h45);
      // one nesting level only, even with the flag set again
      wr(ADDR_CTRL, 8'h01);
      want <= 8'h24;
      no_ack(8);
      pulse_ret(1'b1);
      wait_ack(3'd5, 2'd0);
      `CHK(in_service, 1'b1)
      // mid-run reset with pins high, then an early enable: no false edge
      sys_rst <= 1'b1;
      cyc(2);
      sys_rst <= 1'b0;
      wr(ADDR_RISE, 8'h24);
      rd_chk(ADDR_FALL, 8'h00);
      rd_chk(ADDR_CTRL, 8'h00);
      cyc(4);
      rd_chk(ADDR_STATUS, 8'h00);
      `CHK(in_service, 1'b0)
      end_sim();
   end
endmodule // ext_irq_edge_and_priority_tb_top
